// [core/branch_trace_messaging.sv]
`include "trace_map.svh"
// How it works
// - Trace comes from fetch address, attributes and six-bit pipeline status.
// - Traditional: taken direct branch emits message with sequential count.
// - Traditional: untaken branches just add to the instruction count.
// - Traditional: indirect/exception message carries count plus unique address.
// - History: indirect message carries count, unique address and history.
// - Predicates, direct branches, untaken indirect branches each add history.
// - History bit is one when executed or taken, else zero.
// - Vector-select adds two consecutive history bits.
// - Register-target branches, system calls, traps, returns are indirect sources.
// - Immediate-target taken branches are direct or history sources.
// - Instruction-synchronize counts as a direct branch event.
// - Method bit one selects history, zero selects traditional.
// - History mode queues nothing for direct branches.
// - Traditional messages enter the queue and leave in event order.
// - Direct, indirect and history-indirect kinds are produced here.
// - Runtime-resolved taken branches and exceptions count as indirect.
// - History message: history, address, count, source, code 011100.
// - History indirect message length stays within 13 to 82 bits.
// - Traditional indirect: address, count, source, code 000100.
// - Traditional direct: count, source, code 000011; not in history.
// - Full history buffer sends resource message code 0001 with history.
// - Count reaching 255 resets and sends resource code 0000, data ff.
//
// The pipeline status encoding is a small local code: bits 2:0 carry
// the instruction class decoded by the core, the rest are spare.
module branch_trace_messaging #(
	parameter int          FIFO_DEPTH = 32,
	parameter logic [3:0]  SOURCE_ID  = 4'h0
) (
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Control.
	input  wire logic        trace_enable,
	input  wire logic        trace_method_select,
	// Core observation, valid for one cycle per completed instruction.
	input  wire logic        retire_valid,
	input  wire logic [31:0] virt_addr,
	input  wire logic [5:0]  pipe_status,
	input  wire logic        branch_taken,
	input  wire logic [1:0]  pred_result,
	// Stall toward the core while the message path is full.
	output logic             core_stall,
	// Message stream toward the trace port.
	output logic             msg_valid,
	input  wire logic        msg_ready,
	output trace_pkg::message_t msg_data
);
	localparam int MW = $bits(trace_pkg::message_t);

	trace_pkg::gen_state_t st_r;
	trace_pkg::gen_state_t st_nxt;
	trace_pkg::event_t     ev;
	trace_pkg::message_t   m;
	logic                  rst_int_n;
	logic                  q_ready;
	logic                  q_valid;
	trace_pkg::message_t   q_data;
	logic                  out_vld_r;
	trace_pkg::message_t   out_msg_r;
	logic                  stall_r;
	logic                  take;
	logic                  hist_mode;
	logic [31:0]           xr;
	logic [5:0]            nbits;
	logic [31:0]           h;
	logic [7:0]            cnt;
	logic [6:0]            hlen;
	logic                  hist_full;
	logic [1:0]            rst_sync_r;

	// Reset release through two flip-flops.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_int_n = rst_sync_r[1];

	// Instruction classification from the six-bit pipeline status.
	always_comb begin
		ev = trace_pkg::EV_NONE;
		if (retire_valid && trace_enable) begin
			unique case (pipe_status[2:0])
				3'h1: ev = trace_pkg::EV_SEQ;
				// Immediate-target branches and isync share this code.
				3'h2: ev = trace_pkg::EV_DIRECT;
				// Register-target branches, calls, traps, returns.
				3'h3: ev = trace_pkg::EV_INDIRECT;
				3'h4: ev = trace_pkg::EV_EXCEPT;
				3'h5: ev = trace_pkg::EV_PRED;
				3'h6: ev = trace_pkg::EV_PRED2;
				default: ev = trace_pkg::EV_NONE;
			endcase
		end
	end

	// Leading-one position gives the unique part of the target.
	function automatic logic [5:0] msb_bits(input logic [31:0] v);
		logic [5:0] n;
		n = 6'h01;
		for (int i = 0; i < 32; i++) begin
			if (v[i]) begin
				n = 6'(i + 1);
			end
		end
		return n;
	endfunction

	// Width of the history field up to and including the stop bit.
	function automatic logic [5:0] hist_bits(input logic [31:0] v);
		return msb_bits(v);
	endfunction

	always_comb begin
		st_nxt    = st_r;
		m         = '0;
		take      = 1'b0;
		hist_mode = trace_method_select;
		xr        = virt_addr ^ st_r.last_addr;
		nbits     = msb_bits(xr);
		h         = st_r.hist;
		cnt       = st_r.icnt;
		hlen      = 7'h00;
		// Full at thirty bits, so a vector-select pair keeps its stop bit.
		hist_full = st_r.hist[31] || st_r.hist[30];
		if (st_r.vld && q_ready) begin
			st_nxt.vld = 1'b0;
		end
		// Nothing new is accepted while a message waits for the queue.
		if (!st_r.vld || q_ready) begin
			m.source = SOURCE_ID;
			if (hist_full && hist_mode) begin
				m.tcode   = `TCODE_RES_FULL;
				m.rcode   = `RCODE_HIST_FULL;
				m.history = st_r.hist;
				m.length  = 7'(hist_bits(st_r.hist)) + 7'd14;
				take      = 1'b1;
				st_nxt.hist = `HIST_RESET;
			end else if (st_r.icnt == `ICNT_LIMIT) begin
				m.tcode = `TCODE_RES_FULL;
				m.rcode = `RCODE_COUNT_FULL;
				m.count = `ICNT_LIMIT;
				m.length = 7'd22;
				take     = 1'b1;
				st_nxt.icnt = 8'h00;
			end else begin
				unique case (ev)
					trace_pkg::EV_SEQ: begin
						st_nxt.icnt = cnt + 8'h01;
					end
					trace_pkg::EV_PRED: begin
						if (hist_mode) begin
							// Any history-recording instruction restarts the count.
							st_nxt.icnt = 8'h00;
							st_nxt.hist = {h[30:0], pred_result[0]};
						end else begin
							st_nxt.icnt = cnt + 8'h01;
						end
					end
					trace_pkg::EV_PRED2: begin
						if (hist_mode) begin
							st_nxt.icnt = 8'h00;
							st_nxt.hist = {h[29:0], pred_result};
						end else begin
							st_nxt.icnt = cnt + 8'h01;
						end
					end
					trace_pkg::EV_DIRECT: begin
						if (hist_mode) begin
							st_nxt.icnt = 8'h00;
							st_nxt.hist = {h[30:0], branch_taken};
						end else if (branch_taken) begin
							m.tcode  = `TCODE_DIRECT;
							m.count  = cnt;
							m.length = 7'd18;
							take     = 1'b1;
							st_nxt.icnt = 8'h00;
						end else begin
							st_nxt.icnt = cnt + 8'h01;
						end
					end
					trace_pkg::EV_INDIRECT, trace_pkg::EV_EXCEPT: begin
						if (ev == trace_pkg::EV_INDIRECT && !branch_taken) begin
							if (hist_mode) begin
								st_nxt.icnt = 8'h00;
								st_nxt.hist = {h[30:0], 1'b0};
							end else begin
								st_nxt.icnt = cnt + 8'h01;
							end
						end else begin
							m.count     = cnt;
							m.rel_addr  = xr;
							m.addr_bits = nbits;
							st_nxt.last_addr = virt_addr;
							st_nxt.icnt = 8'h00;
							take        = 1'b1;
							if (hist_mode) begin
								hlen       = 7'(hist_bits(h));
								m.tcode    = `TCODE_INDIRECT_HIST;
								m.history  = h;
								m.length   = hlen + 7'(nbits) + 7'd18;
								st_nxt.hist = `HIST_RESET;
							end else begin
								m.tcode  = `TCODE_INDIRECT;
								m.length = 7'(nbits) + 7'd18;
							end
						end
					end
					default: begin
					end
				endcase
			end
			if (take) begin
				st_nxt.vld = 1'b1;
				st_nxt.msg = m;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			st_r.vld       <= 1'b0;
			st_r.msg       <= '0;
			st_r.icnt      <= 8'h00;
			st_r.hist      <= `HIST_RESET;
			st_r.last_addr <= 32'h0000_0000;
		end else begin
			st_r.vld       <= st_nxt.vld;
			st_r.msg       <= st_nxt.msg;
			st_r.icnt      <= st_nxt.icnt;
			st_r.hist      <= st_nxt.hist;
			st_r.last_addr <= st_nxt.last_addr;
		end
	end

	// Messages keep event order through a single queue.
	msg_fifo #(
		.WIDTH (MW),
		.DEPTH (FIFO_DEPTH)
	) u_queue (
		.clock     (clock),
		.rst_n     (rst_int_n),
		.in_valid  (st_r.vld),
		.in_ready  (q_ready),
		.in_data   (st_r.msg),
		.out_valid (q_valid),
		.out_ready (!out_vld_r || msg_ready),
		.out_data  (q_data)
	);

	// Output register keeps every output straight from a flip-flop.
	always_ff @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			out_vld_r <= 1'b0;
			out_msg_r <= '0;
			stall_r   <= 1'b0;
		end else begin
			if (!out_vld_r || msg_ready) begin
				out_vld_r <= q_valid;
				out_msg_r <= q_data;
			end
			// Also hold the core off while a resource report is due, since
			// that report takes the cycle and an event there would be lost.
			stall_r <= st_nxt.vld || st_nxt.icnt == `ICNT_LIMIT
				|| (hist_mode && (st_nxt.hist[31] || st_nxt.hist[30]));
		end
	end

	assign msg_valid  = out_vld_r;
	assign msg_data   = out_msg_r;
	// The core must hold retirement while a message is pending.
	assign core_stall = stall_r;

	chk_direct_traditional: assert property (@(posedge clock)
		disable iff (!rst_int_n)
		(ev == trace_pkg::EV_DIRECT && branch_taken && !hist_mode
		&& !st_r.vld && !hist_full && st_r.icnt != `ICNT_LIMIT)
		|=> st_r.vld && st_r.msg.tcode == `TCODE_DIRECT)
		else $error("taken direct branch gave no message");
	chk_history_no_direct: assert property (@(posedge clock)
		disable iff (!rst_int_n)
		(hist_mode && st_r.vld) |-> st_r.msg.tcode != `TCODE_DIRECT)
		else $error("direct message queued in history mode");
	chk_untaken_counts: assert property (@(posedge clock)
		disable iff (!rst_int_n)
		(ev == trace_pkg::EV_DIRECT && !branch_taken && !st_r.vld
		&& !hist_mode && st_r.icnt < 8'hfe)
		|=> st_r.icnt == $past(st_r.icnt) + 8'h01)
		else $error("untaken branch not counted");
	chk_hist_count_clear: assert property (@(posedge clock)
		disable iff (!rst_int_n)
		(ev == trace_pkg::EV_PRED && hist_mode && !st_r.vld && !hist_full
		&& st_r.icnt != `ICNT_LIMIT) |=> st_r.icnt == 8'h00)
		else $error("predicate did not restart the count");
	chk_hist_length: assert property (@(posedge clock)
		disable iff (!rst_int_n)
		(st_r.vld && st_r.msg.tcode == `TCODE_INDIRECT_HIST)
		|-> st_r.msg.length >= `HIST_MSG_MIN_BITS
		&& st_r.msg.length <= `HIST_MSG_MAX_BITS)
		else $error("history message length out of range");
	chk_count_wrap: assert property (@(posedge clock)
		disable iff (!rst_int_n)
		(st_r.icnt == `ICNT_LIMIT && !(hist_full && hist_mode)
		&& (!st_r.vld || q_ready))
		|=> st_r.icnt == 8'h00 && st_r.msg.rcode == `RCODE_COUNT_FULL)
		else $error("count limit not reported");
	chk_stall_count_full: assert property (@(posedge clock)
		disable iff (!rst_int_n)
		st_r.icnt == `ICNT_LIMIT |-> core_stall)
		else $error("core not held while count report is due");
	chk_stop_bit: assert property (@(posedge clock)
		disable iff (!rst_int_n)
		st_r.hist != 32'h0000_0000)
		else $error("history lost its stop bit");
	chk_pair_bits: assert property (@(posedge clock)
		disable iff (!rst_int_n)
		(ev == trace_pkg::EV_PRED2 && hist_mode && !st_r.vld && !hist_full
		&& st_r.icnt != `ICNT_LIMIT)
		|=> st_r.hist[1:0] == $past(pred_result))
		else $error("vector select bits not recorded");
	chk_hist_full_msg: assert property (@(posedge clock)
		disable iff (!rst_int_n)
		(hist_full && hist_mode && !st_r.vld)
		|=> st_r.msg.rcode == `RCODE_HIST_FULL
		&& st_r.hist == `HIST_RESET)
		else $error("full history not reported");
	chk_indirect_trad: assert property (@(posedge clock)
		disable iff (!rst_int_n)
		(st_r.vld && !hist_mode && st_r.msg.tcode == `TCODE_INDIRECT)
		|-> st_r.msg.history == 32'h0000_0000)
		else $error("traditional indirect carries history");

	cov_direct_msg: cover property (@(posedge clock)
		st_r.vld && st_r.msg.tcode == `TCODE_DIRECT);
	cov_hist_msg: cover property (@(posedge clock)
		st_r.vld && st_r.msg.tcode == `TCODE_INDIRECT_HIST);
	cov_res_full: cover property (@(posedge clock)
		st_r.vld && st_r.msg.tcode == `TCODE_RES_FULL);
	cov_stall: cover property (@(posedge clock) core_stall && !msg_ready);
	cov_hist_full: cover property (@(posedge clock)
		hist_full && hist_mode && !st_r.vld);
endmodule // branch_trace_messaging

// [core/trace_map.svh]
`ifndef TRACE_MAP_SVH
`define TRACE_MAP_SVH

// Transfer codes.
`define TCODE_DIRECT        6'h03
`define TCODE_INDIRECT      6'h04
`define TCODE_RES_FULL      6'h1b
`define TCODE_INDIRECT_HIST 6'h1c
// Resource codes.
`define RCODE_COUNT_FULL    4'h0
`define RCODE_HIST_FULL     4'h1
// Instruction counter limit and data sent with it.
`define ICNT_LIMIT          8'hff
// Message length limits, history indirect message.
`define HIST_MSG_MIN_BITS   7'h0d
`define HIST_MSG_MAX_BITS   7'h52
// History buffer value after reset: stop bit only.
`define HIST_RESET          32'h0000_0001

`endif

// [core/trace_pkg.sv]
package trace_pkg;

	// Event class decoded from pipeline status bits 2:0 alone.
	typedef enum logic [2:0] {
		EV_NONE     = 3'b000,
		EV_SEQ      = 3'b001,
		EV_DIRECT   = 3'b010,
		EV_INDIRECT = 3'b011,
		EV_EXCEPT   = 3'b100,
		EV_PRED     = 3'b101,
		EV_PRED2    = 3'b110
	} event_t;

	// One observed instruction completion.
	typedef struct packed {
		logic [31:0] addr;
		logic [5:0]  pstat;
		logic        taken;
		logic [1:0]  pred;
	} observe_t;

	// One trace message entering the message queue.
	typedef struct packed {
		logic [5:0]  tcode;
		logic [3:0]  source;
		logic [7:0]  count;
		logic [31:0] rel_addr;
		logic [5:0]  addr_bits;
		logic [31:0] history;
		logic [3:0]  rcode;
		logic [6:0]  length;
	} message_t;

	// Generator state.
	typedef struct packed {
		logic        vld;
		message_t    msg;
		logic [7:0]  icnt;
		logic [31:0] hist;
		logic [31:0] last_addr;
	} gen_state_t;

	// Queue state.
	typedef struct packed {
		logic [5:0] wptr;
		logic [5:0] rptr;
	} fifo_state_t;

endpackage

// [core/msg_fifo.sv]
module msg_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset.
	input  wire logic             clock,
	input  wire logic             rst_n,
	// Filling side.
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wptr_r;
	logic [AW:0]      rptr_r;
	logic [AW:0]      wptr_nxt;
	logic [AW:0]      rptr_nxt;
	logic             push;
	logic             pop;

	always_comb begin
		in_ready  = (wptr_r - rptr_r) != (AW+1)'(DEPTH);
		out_valid = wptr_r != rptr_r;
		out_data  = mem[rptr_r[AW-1:0]];
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		wptr_nxt  = wptr_r + (AW+1)'(push);
		rptr_nxt  = rptr_r + (AW+1)'(pop);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wptr_r <= '0;
			rptr_r <= '0;
		end else begin
			wptr_r <= wptr_nxt;
			rptr_r <= rptr_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wptr_r[AW-1:0]] <= in_data;
		end
	end

	chk_fifo_no_overfill: assert property (@(posedge clock)
		disable iff (!rst_n)
		(wptr_r - rptr_r) <= (AW+1)'(DEPTH))
		else $error("fifo holds more than its depth");
endmodule // msg_fifo

// [sim/trace_sink.sv]
// Behavioural model of the development tool draining the trace port.
module trace_sink (
	// Clock and reset.
	input  wire logic          clock,
	input  wire logic          rst_n,
	// Pacing controls from the bench.
	input  wire logic          hold,
	input  wire logic          slow,
	// Message stream from the block.
	input  wire logic          msg_valid,
	input  trace_pkg::message_t msg_data,
	output logic               msg_ready,
	// Accepted message, one cycle after the handshake.
	output logic               got,
	output trace_pkg::message_t got_msg
);
	timeunit 1ns;
	timeprecision 1ns;

	logic phase_r;

	// Slow pacing offers ready only every other cycle, like a busy pin port.
	assign msg_ready = rst_n && !hold && (!slow || phase_r);

	// Messages are taken strictly in arrival order.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= 1'b0;
			got     <= 1'b0;
			got_msg <= '0;
		end else begin
			phase_r <= !phase_r;
			got     <= msg_valid && msg_ready;
			if (msg_valid && msg_ready)
				got_msg <= msg_data;
		end
	end
endmodule // trace_sink

// [sim/branch_trace_messaging_tb.sv]
`include "trace_map.svh"
module branch_trace_messaging_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic                clock = 1'b0;
	logic                rst_n = 1'b0;
	logic                trace_enable = 1'b0;
	logic                trace_method_select = 1'b0;
	logic                retire_valid = 1'b0;
	logic [31:0]         virt_addr = 32'h0000_0000;
	logic [5:0]          pipe_status = 6'h00;
	logic                branch_taken = 1'b0;
	logic [1:0]          pred_result = 2'h0;
	logic                hold = 1'b0;
	logic                slow = 1'b0;
	logic                core_stall;
	logic                msg_valid;
	logic                msg_ready;
	logic                got;
	trace_pkg::message_t msg_data;
	trace_pkg::message_t got_msg;
	trace_pkg::message_t q[$];
	trace_pkg::message_t m;
	int                  error_cnt = 0;
	int                  cmp_count = 0;
	int                  gap = 3;

	always #20 clock = ~clock;

	branch_trace_messaging u_dut (
		.clock(clock), .rst_n(rst_n), .trace_enable(trace_enable),
		.trace_method_select(trace_method_select),
		.retire_valid(retire_valid), .virt_addr(virt_addr),
		.pipe_status(pipe_status), .branch_taken(branch_taken),
		.pred_result(pred_result), .core_stall(core_stall),
		.msg_valid(msg_valid), .msg_ready(msg_ready), .msg_data(msg_data)
	);

	trace_sink u_sink (
		.clock(clock), .rst_n(rst_n), .hold(hold), .slow(slow),
		.msg_valid(msg_valid), .msg_data(msg_data), .msg_ready(msg_ready),
		.got(got), .got_msg(got_msg)
	);

	always @(posedge clock) begin
		if (got === 1'b1)
			q.push_back(got_msg);
	end

	task automatic check(input string name, input logic [63:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic do_reset(input logic meth);
		rst_n = 1'b0;
		trace_method_select = meth;
		repeat (10) @(negedge clock);
		rst_n = 1'b1;
		repeat (4) @(negedge clock);
		q.delete();
	endtask

	// One retired instruction; waits out a stall first, since the core
	// must not retire while the message path is full.
	task automatic ev(input logic [2:0] cls, input logic tk,
			input logic [1:0] pr, input logic [31:0] a);
		int n;
		n = 0;
		while (core_stall !== 1'b0 && n < 1000) begin
			@(negedge clock);
			n++;
		end
		if (n >= 1000)
			error_cnt++;
		pipe_status = {3'h0, cls};
		branch_taken = tk;
		pred_result = pr;
		virt_addr = a;
		retire_valid = 1'b1;
		@(negedge clock);
		retire_valid = 1'b0;
		repeat (gap) @(negedge clock);
	endtask

	task automatic wait_msgs(input int n);
		int k;
		k = 0;
		while (q.size() < n && k < 3000) begin
			@(negedge clock);
			k++;
		end
		check("msg_count", q.size(), n);
	endtask

	task automatic t_trad;
		do_reset(1'b0);
		slow = 1'b1;
		ev(3'h2, 1'b1, 2'h0, 32'h0000_0040);
		repeat (10) @(negedge clock);
		check("disabled_msgs", q.size(), 0);
		trace_enable = 1'b1;
		repeat (3) ev(3'h1, 1'b0, 2'h0, 32'h0000_0000);
		ev(3'h2, 1'b1, 2'h0, 32'h0000_0040);
		wait_msgs(1);
		m = q.pop_front();
		check("dir_tcode", m.tcode, `TCODE_DIRECT);
		check("dir_count", m.count, 8'h03);
		check("dir_source", m.source, 4'h0);
		ev(3'h2, 1'b0, 2'h0, 32'h0000_0000);
		ev(3'h3, 1'b0, 2'h0, 32'h0000_0000);
		ev(3'h1, 1'b0, 2'h0, 32'h0000_0000);
		ev(3'h3, 1'b1, 2'h0, 32'h0000_0100);
		ev(3'h4, 1'b0, 2'h0, 32'h0000_0180);
		wait_msgs(2);
		m = q.pop_front();
		check("ind_tcode", m.tcode, `TCODE_INDIRECT);
		check("ind_count", m.count, 8'h03);
		check("ind_rel", m.rel_addr, 32'h0000_0100);
		check("ind_bits", m.addr_bits, 6'h09);
		check("ind_len", m.length, 7'h1b);
		m = q.pop_front();
		check("exc_tcode", m.tcode, `TCODE_INDIRECT);
		check("exc_count", m.count, 8'h00);
		check("exc_rel", m.rel_addr, 32'h0000_0080);
		check("exc_bits", m.addr_bits, 6'h08);
		slow = 1'b0;
	endtask

	task automatic t_hist;
		do_reset(1'b1);
		ev(3'h2, 1'b1, 2'h0, 32'h0000_0040);
		ev(3'h5, 1'b0, 2'h0, 32'h0000_0000);
		ev(3'h6, 1'b0, 2'h2, 32'h0000_0000);
		ev(3'h3, 1'b0, 2'h0, 32'h0000_0000);
		repeat (8) @(negedge clock);
		check("hist_no_direct", q.size(), 0);
		ev(3'h1, 1'b0, 2'h0, 32'h0000_0000);
		ev(3'h3, 1'b1, 2'h0, 32'h0000_0200);
		wait_msgs(1);
		m = q.pop_front();
		check("hist_tcode", m.tcode, `TCODE_INDIRECT_HIST);
		check("hist_field", m.history, 32'h0000_0034);
		check("hist_rel", m.rel_addr, 32'h0000_0200);
		check("hist_bits", m.addr_bits, 6'h0a);
		check("hist_count", m.count, 8'h01);
		check("hist_len_ok", m.length >= `HIST_MSG_MIN_BITS
			&& m.length <= `HIST_MSG_MAX_BITS, 1'b1);
	endtask

	task automatic t_cnt;
		do_reset(1'b0);
		pipe_status = 6'h01;
		retire_valid = 1'b1;
		repeat (255) @(negedge clock);
		retire_valid = 1'b0;
		repeat (3) @(negedge clock);
		ev(3'h2, 1'b1, 2'h0, 32'h0000_0040);
		wait_msgs(2);
		m = q.pop_front();
		check("full_tcode", m.tcode, `TCODE_RES_FULL);
		check("full_rcode", m.rcode, `RCODE_COUNT_FULL);
		check("full_data", m.count, 8'hff);
		m = q.pop_front();
		check("after_full_count", m.count, 8'h00);
	endtask

	// Thirty set predicates fill the history; the full report keeps the
	// stop bit and the next indirect message starts from an empty field.
	task automatic t_hfull;
		do_reset(1'b1);
		repeat (30) ev(3'h5, 1'b1, 2'h1, 32'h0000_0000);
		wait_msgs(1);
		m = q.pop_front();
		check("hfull_tcode", m.tcode, `TCODE_RES_FULL);
		check("hfull_rcode", m.rcode, `RCODE_HIST_FULL);
		check("hfull_hist", m.history, 32'h7fff_ffff);
		ev(3'h3, 1'b1, 2'h0, 32'h0000_0010);
		wait_msgs(1);
		m = q.pop_front();
		check("hfull_next", m.history, 32'h0000_0001);
	endtask

	// Fill the queue with the sink stalled until the core is held off,
	// then drain slowly and expect every message back as a direct message with count zero.
	task automatic t_fill;
		int n;
		do_reset(1'b0);
		hold = 1'b1;
		n = 0;
		while (core_stall !== 1'b1 && n < 40) begin
			ev(3'h2, 1'b1, 2'h0, 32'h0000_0040);
			n++;
		end
		check("fill_stall", core_stall, 1'b1);
		check("fill_deep", n >= 32, 1'b1);
		hold = 1'b0;
		slow = 1'b1;
		wait_msgs(n);
		while (q.size() > 0) begin
			m = q.pop_front();
			check("fill_tcode", m.tcode, `TCODE_DIRECT);
			check("fill_count", m.count, 8'h00);
		end
		repeat (4) @(negedge clock);
		check("drain_stall", core_stall, 1'b0);
		slow = 1'b0;
	endtask

	initial begin
		#2000000;
		error_cnt++;
		end_of_test();
	end

	initial begin
		t_trad();
		trace_enable = 1'b1;
		t_hist();
		t_hfull();
		t_cnt();
		t_fill();
		end_of_test();
	end
endmodule // branch_trace_messaging_tb
